//--- design/pbf_pkg.sv
/*
 * Constants for the port B pin function select block: register offsets,
 * writable masks, reset values and select-bit positions per pin.
 * Assumes a 32-bit AXI4-Lite register bus; each register takes one word.
 */
package pbf_pkg;

   // =========================================================
   // geometry
   localparam int PBF_NPINS = 14;
   localparam int PBF_AW = 4;

   // =========================================================
   // register byte offsets
   localparam logic [PBF_AW-1:0] PBF_OFF_DIR = 4'h0;
   localparam logic [PBF_AW-1:0] PBF_OFF_SEL1 = 4'h4;
   localparam logic [PBF_AW-1:0] PBF_OFF_SEL2 = 4'h8;

   // =========================================================
   // writable masks and reset values
   localparam logic [15:0] PBF_DIR_MASK = 16'h3FFF;
   localparam logic [15:0] PBF_SEL1_MASK = 16'h0555;
   localparam logic [15:0] PBF_SEL2_MASK = 16'h5555;
   localparam logic [15:0] PBF_DIR_RESET = 16'h0000;
   localparam logic [15:0] PBF_SEL1_RESET = 16'h0000;
   localparam logic [15:0] PBF_SEL2_RESET = 16'h0000;

   // =========================================================
   // AXI responses
   localparam logic [1:0] PBF_RESP_OKAY = 2'h0;
   localparam logic [1:0] PBF_RESP_SLVERR = 2'h2;

   // pins 13..8 live in select register 1, pins 7..0 in register 2;
   // pin n's bit is 2*(n mod 8) in its register
   localparam int PBF_SEL1_FIRST_PIN = 8;

endpackage

//--- design/pbf_port_b_function_select.sv
/*
 * Port B pin function select: direction register and two function select
 * registers behind an AXI4-Lite slave, plus the per-pin mux between
 * general port I/O and the bus state controller signals.
 * Assumes the pad ring resolves pin levels from out/oe, and that the bus
 * state controller supplies its strobes as active-level values with enables.
 */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pbf_port_b_function_select
   import pbf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic [13:0] pin_in,
   output logic [13:0] pin_out,
   output logic [13:0] pin_oe,
   // general port side
   input wire logic [13:0] port_out,
   output logic [13:0] port_in,
   // bus state controller side
   input wire logic bus_cycle_start_strobe,
   input wire logic area3_chip_select,
   input wire logic area4_chip_select,
   input wire logic area5_chip_select,
   input wire logic area6_chip_select,
   input wire logic card_a_enable_2,
   input wire logic card_b_enable_2,
   input wire logic card_io_write_strobe,
   input wire logic card_io_read_strobe,
   input wire logic row_address_strobe,
   input wire logic column_address_strobe,
   input wire logic sync_clock_enable,
   input wire logic [13:2] bsc_oe,
   output logic card_io_16bit_indicator,
   output logic wait_request
);

   // =========================================================
   // registers
   logic [15:0] port_b_direction;
   logic [15:0] port_b_function_sel_1;
   logic [15:0] port_b_function_sel_2;

   function automatic logic [15:0] pbf_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st,
                                             input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (st[0]) begin
         v[7:0] = wd[7:0];
      end
      if (st[1]) begin
         v[15:8] = wd[15:8];
      end
      return v & mask;
   endfunction

   function automatic logic [2:0] pbf_decode(input logic [31:0] a);
      logic [2:0] hit;
      hit = 3'h0;
      if (a[31:PBF_AW] == '0) begin
         hit[0] = (a[PBF_AW-1:0] == PBF_OFF_DIR);
         hit[1] = (a[PBF_AW-1:0] == PBF_OFF_SEL1);
         hit[2] = (a[PBF_AW-1:0] == PBF_OFF_SEL2);
      end
      return hit;
   endfunction

   // =========================================================
   // write channel: address and data latched separately, any order
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire [2:0] wr_hit = pbf_decode(aw_addr);

   always_ff @(posedge clock) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PBF_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
         s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_hit != 3'h0) ? PBF_RESP_OKAY : PBF_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // reserved bits masked on write so they always read as zero
   always_ff @(posedge clock) begin
      if (rst) begin
         port_b_direction <= PBF_DIR_RESET;
         port_b_function_sel_1 <= PBF_SEL1_RESET;
         port_b_function_sel_2 <= PBF_SEL2_RESET;
      end else if (wr_fire) begin
         if (wr_hit[0]) begin
            port_b_direction <= pbf_merge(port_b_direction, w_data, w_strb,
                                          PBF_DIR_MASK);
         end
         if (wr_hit[1]) begin
            port_b_function_sel_1 <= pbf_merge(port_b_function_sel_1, w_data,
                                               w_strb, PBF_SEL1_MASK);
         end
         if (wr_hit[2]) begin
            port_b_function_sel_2 <= pbf_merge(port_b_function_sel_2, w_data,
                                               w_strb, PBF_SEL2_MASK);
         end
      end
   end

   // =========================================================
   // read channel
   wire [2:0] rd_hit = pbf_decode(s_axi_araddr);
   wire [15:0] rd_word = ({16{rd_hit[0]}} & port_b_direction)
                       | ({16{rd_hit[1]}} & port_b_function_sel_1)
                       | ({16{rd_hit[2]}} & port_b_function_sel_2);
   wire ar_take = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PBF_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= (rd_hit != 3'h0) ? PBF_RESP_OKAY : PBF_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =========================================================
   // pin mux
   // one select bit per pin, at even positions of its register
   wire [13:0] func_sel;
   genvar gi;
   generate
      for (gi = 0; gi < PBF_NPINS; gi++) begin : g_sel
         if (gi >= PBF_SEL1_FIRST_PIN) begin : g_hi
            assign func_sel[gi] = port_b_function_sel_1[2*(gi-PBF_SEL1_FIRST_PIN)];
         end else begin : g_lo
            assign func_sel[gi] = port_b_function_sel_2[2*gi];
         end
      end
   endgenerate

   // area5/area6 selects share their pins with card enables 1
   wire [13:2] bsc_val = {bus_cycle_start_strobe,
                          area3_chip_select,
                          area4_chip_select,
                          area5_chip_select,
                          card_a_enable_2,
                          area6_chip_select,
                          card_b_enable_2,
                          card_io_write_strobe,
                          card_io_read_strobe,
                          row_address_strobe,
                          column_address_strobe,
                          sync_clock_enable};
   // pins 1 and 0 are inputs in their bus function: never driven then
   wire [13:0] bsc_oe_full = {bsc_oe, 2'b00};
   wire [13:0] bsc_val_full = {bsc_val, 2'b00};
   wire [13:0] gpio_oe = port_b_direction[13:0];
   // direction only counts for pins in general I/O
   wire [13:0] next_pin_oe = (func_sel & bsc_oe_full) | (~func_sel & gpio_oe);
   wire [13:0] next_pin_out = (func_sel & bsc_val_full) | (~func_sel & port_out);

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_oe <= 14'h0000;
         pin_out <= 14'h0000;
         port_in <= 14'h0000;
         card_io_16bit_indicator <= 1'b0;
         wait_request <= 1'b0;
      end else begin
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out;
         port_in <= pin_in & ~func_sel;
         card_io_16bit_indicator <= func_sel[1] & pin_in[1];
         wait_request <= func_sel[0] & pin_in[0];
      end
   end

endmodule

//--- test/pbf_bsc_model.sv
/* Bus controller stand-in: strobe values and drive enables for pins 13..2.
   Assumes one clock shared with the port block. */
`timescale 1ns/1ps
module pbf_bsc_model (
   input wire logic clock,
   input wire logic rst,
   output logic [13:2] bsc_val,
   output logic [13:2] bsc_oe
);
   // ==========================================================
   // pattern source
   // values move every cycle so a stale or crossed mux path shows
   always_ff @(posedge clock) begin
      if (rst) begin
         bsc_val <= 12'hA5C;
         bsc_oe <= 12'h3C6;
      end else begin
         bsc_val <= {bsc_val[10:0], bsc_val[11] ^ bsc_val[5]};
         bsc_oe <= bsc_oe + 12'h5B3;
      end
   end
endmodule

//--- test/pbf_properties.sv
/* Checker for the pin mux outputs and register read data.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module pbf_properties
   import pbf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [13:0] pin_in,
   input wire logic [13:0] pin_out,
   input wire logic [13:0] pin_oe,
   input wire logic [13:0] port_out,
   input wire logic [13:0] port_in,
   input wire logic [13:2] bsc_oe,
   input wire logic bus_cycle_start_strobe,
   input wire logic card_io_16bit_indicator,
   input wire logic wait_request
);
   // ==========================================================
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   reset_quiet_a: assert property ($past(rst) |-> pin_oe == 14'h0000 && !s_axi_rvalid)
      else $error("outputs not quiet after reset");
   port_follow_a: assert property ((port_in & ~$past(pin_in)) == 14'h0000)
      else $error("port input does not follow pin");
   port_drive_a: assert property (port_in[13] |-> pin_out[13] == $past(port_out[13]))
      else $error("port pin not driven from port");
   oe_port_a: assert property (pin_oe[12] && !$past(bsc_oe[12])
      |-> pin_out[12] == $past(port_out[12]))
      else $error("enabled pin without port value");
   bus_drive_a: assert property (!$past(rst) && $past(pin_in[13]) && !port_in[13]
      |-> pin_oe[13] == $past(bsc_oe[13]) && pin_out[13] == $past(bus_cycle_start_strobe))
      else $error("pin 13 not driven by bus side");
   wait_in_a: assert property (wait_request |-> !pin_oe[0] && !port_in[0] && $past(pin_in[0]))
      else $error("wait input path wrong");
   ind_in_a: assert property (card_io_16bit_indicator |-> !pin_oe[1] && !port_in[1]
      && $past(pin_in[1]))
      else $error("indicator input path wrong");
   rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000)
      else $error("reserved read bits set");
   cover property (wait_request);
   cover property (card_io_16bit_indicator);
   cover property (s_axi_bvalid && s_axi_bresp == PBF_RESP_SLVERR);
endmodule

bind pbf_port_b_function_select pbf_properties u_props (.clock, .rst, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .pin_in, .pin_out, .pin_oe, .port_out,
   .port_in, .bsc_oe, .bus_cycle_start_strobe, .card_io_16bit_indicator, .wait_request);

//--- test/tb_top.sv
/* Self-checking bench for the port B pin function select block.
   Assumes the package, the checker and the bus controller stand-in. */
`timescale 1ns/1ps
module tb_top import pbf_pkg::*; ;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, look = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [13:0] pin_in = 14'h0000, port_out = 14'h0000, fs = 14'h0000;
   logic [13:0] pin_out, pin_oe, port_in;
   logic [13:2] bsc_val, bsc_oe;
   logic card_io_16bit_indicator, wait_request;
   logic [63:0] q[$];
   int n_errors = 0, n_checks = 0, cyc = 0;
   logic [3:0] offs[3] = '{PBF_OFF_DIR, PBF_OFF_SEL1, PBF_OFF_SEL2};
   logic [15:0] msks[3] = '{PBF_DIR_MASK, PBF_SEL1_MASK, PBF_SEL2_MASK};

   pbf_bsc_model u_bsc (.clock, .rst, .bsc_val, .bsc_oe);
   pbf_port_b_function_select dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pin_in, .pin_out, .pin_oe, .port_out, .port_in, .bsc_oe,
      .bus_cycle_start_strobe(bsc_val[13]), .area3_chip_select(bsc_val[12]),
      .area4_chip_select(bsc_val[11]), .area5_chip_select(bsc_val[10]),
      .card_a_enable_2(bsc_val[9]), .area6_chip_select(bsc_val[8]),
      .card_b_enable_2(bsc_val[7]), .card_io_write_strobe(bsc_val[6]),
      .card_io_read_strobe(bsc_val[5]), .row_address_strobe(bsc_val[4]),
      .column_address_strobe(bsc_val[3]), .sync_clock_enable(bsc_val[2]),
      .card_io_16bit_indicator, .wait_request);

   // ==========================================================
   // tasks
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [63:0] got);
      logic [63:0] exp;
      exp = q.pop_front();
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clock);
      q.push_back({30'h0, r, 32'h0});
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      @(posedge clock);
      q.push_back({30'h0, e});
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // bits 1:0 of pin_out are don't-care while those pins are bus inputs
   task automatic pins(input logic [13:0] f);
      logic [15:0] s1;
      logic [15:0] s2;
      logic [13:0] d;
      s1 = 16'h0000;
      s2 = 16'h0000;
      d = 14'($urandom);
      for (int i = 0; i < 14; i++) begin
         if (i < 8) s2[2*i] = f[i];
         else s1[2*(i-8)] = f[i];
      end
      wr(PBF_OFF_DIR, {18'h0, d}, PBF_RESP_OKAY);
      wr(PBF_OFF_SEL1, {16'h0, s1}, PBF_RESP_OKAY);
      wr(PBF_OFF_SEL2, {16'h0, s2}, PBF_RESP_OKAY);
      fs = f;
      port_out <= 14'($urandom);
      pin_in <= 14'($urandom);
      @(posedge clock);
      q.push_back({20'h0, (d & ~f) | ({bsc_oe, 2'b00} & f), (port_out & ~f)
         | ({bsc_val, 2'b00} & f), pin_in & ~f, f[1] & pin_in[1], f[0] & pin_in[0]});
      look <= 1'b1;
      @(posedge clock);
      look <= 1'b0;
   endtask

   // ==========================================================
   // clock, monitor, timeout, sequence
   initial forever #20 clock = ~clock;

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (s_axi_bvalid && s_axi_bready) cmp({30'h0, s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) cmp({30'h0, s_axi_rresp, s_axi_rdata});
      if (look) cmp({20'h0, pin_oe, pin_out & ~{12'h000, fs[1:0]}, port_in,
         card_io_16bit_indicator, wait_request});
      if (cyc == 5000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      logic [15:0] v;
      void'($urandom(69));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         rd(offs[i], {PBF_RESP_OKAY, 32'h0});
         v = 16'($urandom) & msks[i];
         wr(offs[i], {16'h0, v}, PBF_RESP_OKAY);
         rd(offs[i], {PBF_RESP_OKAY, 16'h0, v});
      end
      // low byte strobe only: the upper byte of select register 2 keeps its value
      s_axi_wstrb <= 4'h1;
      wr(PBF_OFF_SEL2, 32'h0000_FFFF, PBF_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(PBF_OFF_SEL2, {PBF_RESP_OKAY, 16'h0, v[15:8], 8'h55});
      wr(4'hC, 32'h1, PBF_RESP_SLVERR);
      rd(4'hC, {PBF_RESP_SLVERR, 32'h0});
      pins(14'h0000);
      for (int n = 0; n < 14; n++) begin
         pins(14'h0001 << n);
      end
      pins(14'h3FFF);
      repeat (4) pins(14'($urandom));
      conclude();
   end
endmodule
